/* common/mpss_pkg.sv */
// package for the motor parameter set selector: option codes, widths, carriers.
// assumes a single 10 MHz control clock and 8 programmable input terminals.
package mpss_pkg;

  // ****************************************************************
  // option codes held in the terminal-function slots
  // ****************************************************************
  localparam int         FUNC_W          = 8;
  localparam logic [7:0] OPT_SECOND_MOTOR = 8'h08;
  localparam logic [7:0] OPT_ALT_RAMP     = 8'h09;
  localparam logic [7:0] OPT_THIRD_MOTOR  = 8'h11;
  localparam logic [1:0] RAMP_METHOD_TERM = 2'h0;
  localparam int         TERMINALS        = 8;
  localparam int         TIME_W           = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MPSS_SET_FIRST  = 3'b001,
    MPSS_SET_SECOND = 3'b010,
    MPSS_SET_THIRD  = 3'b100
  } mpss_set_t;

  typedef struct packed {
    logic [TIME_W-1:0] accel_time;
    logic [TIME_W-1:0] decel_time;
  } mpss_ramp_t;

  localparam mpss_ramp_t RAMP_RESET = '{accel_time: 16'h0000, decel_time: 16'h0000};

endpackage

/* hw/mpss_select.sv */
// motor parameter set and ramp pair selection for the inverter control core.
// assumes terminal pins are asynchronous and the run/stop state comes from core logic.
// assumes the option codes in the slots stay put while their pins are in use.
`timescale 1ns/1ps
`default_nettype none

module mpss_select #(
  parameter int TERMS = mpss_pkg::TERMINALS
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  input  wire logic [TERMS-1:0]                     term_pin,
  input  wire logic [TERMS-1:0][mpss_pkg::FUNC_W-1:0] input_terminal_func,
  input  wire logic                                 motor_stopped,
  input  wire logic [1:0]                           ramp_switch_method,
  input  wire mpss_pkg::mpss_ramp_t                 ramp_first,
  input  wire mpss_pkg::mpss_ramp_t                 ramp_second,
  output var  mpss_pkg::mpss_set_t                  motor_set,
  output var  mpss_pkg::mpss_ramp_t                 ramp_active,
  output logic                                      ramp_second_active
);

  // elaboration guard: the decode is sized for the slots that exist
  if (TERMS < 1 || TERMS > mpss_pkg::TERMINALS) begin : g_bad_terms
    $error("mpss_select: TERMS out of range");
  end
  // a slot must be wide enough to hold the widest option code
  if (mpss_pkg::FUNC_W < $bits(mpss_pkg::OPT_THIRD_MOTOR)) begin : g_bad_func_w
    $error("mpss_select: FUNC_W too narrow for the option codes");
  end

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [TERMS-1:0] sync_a;
  logic [TERMS-1:0] sync_b;
  logic [TERMS-1:0] next_sync_a;
  logic [TERMS-1:0] next_sync_b;

  // two flops per pin; a contact change lands two or three edges later
  always_comb begin
    next_sync_a = term_pin;
    next_sync_b = sync_a;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  // ****************************************************************
  // function decode per terminal
  // ****************************************************************
  logic [TERMS-1:0] hit_second;
  logic [TERMS-1:0] hit_third;
  logic [TERMS-1:0] hit_ramp;

  genvar gi;
  generate
    for (gi = 0; gi < TERMS; gi++) begin : g_term
      // every slot decodes every function, so any of the three may appear anywhere
      assign hit_second[gi] = sync_b[gi] &&
        (input_terminal_func[gi] == mpss_pkg::OPT_SECOND_MOTOR);
      assign hit_third[gi]  = sync_b[gi] &&
        (input_terminal_func[gi] == mpss_pkg::OPT_THIRD_MOTOR);
      assign hit_ramp[gi]   = sync_b[gi] &&
        (input_terminal_func[gi] == mpss_pkg::OPT_ALT_RAMP);

      // checked from each pin, so a second-set or ramp decode gap in any slot shows up
      slot_second_a : assert property (@(posedge sys_clk) disable iff (!nrst)
        term_pin[gi] && input_terminal_func[gi] == mpss_pkg::OPT_SECOND_MOTOR
          ##2 motor_stopped && !(|hit_third)
            && input_terminal_func[gi] == mpss_pkg::OPT_SECOND_MOTOR
          |=> motor_set == mpss_pkg::MPSS_SET_SECOND)
        else $error("second set from a slot not taken");

      slot_ramp_a : assert property (@(posedge sys_clk) disable iff (!nrst)
        term_pin[gi] && input_terminal_func[gi] == mpss_pkg::OPT_ALT_RAMP
          ##2 ramp_switch_method == mpss_pkg::RAMP_METHOD_TERM
            && input_terminal_func[gi] == mpss_pkg::OPT_ALT_RAMP
          |=> ramp_second_active)
        else $error("ramp pair from a slot not taken");
    end
  endgenerate

  // ****************************************************************
  // motor set selection
  // ****************************************************************
  mpss_pkg::mpss_set_t req_set;
  mpss_pkg::mpss_set_t next_motor_set;

  always_comb begin
    // third over second is our pick; nothing orders the two pins
    if (|hit_third) begin
      req_set = mpss_pkg::MPSS_SET_THIRD;
    end else if (|hit_second) begin
      req_set = mpss_pkg::MPSS_SET_SECOND;
    end else begin
      req_set = mpss_pkg::MPSS_SET_FIRST;
    end
    // a change while running stays pending; req_set keeps tracking the pins
    next_motor_set = motor_stopped ? req_set : motor_set;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      motor_set <= mpss_pkg::MPSS_SET_FIRST;
    end else begin
      motor_set <= next_motor_set;
    end
  end

  // ****************************************************************
  // ramp pair selection
  // ****************************************************************
  // the ramp generator sits outside; only the chosen pair leaves here
  logic                 next_ramp_second_active;
  mpss_pkg::mpss_ramp_t next_ramp_active;

  always_comb begin
    // method other than terminal input leaves the terminal ignored
    next_ramp_second_active = (|hit_ramp) &&
      (ramp_switch_method == mpss_pkg::RAMP_METHOD_TERM);
    // applied regardless of ramp progress, so a running ramp changes rate
    next_ramp_active = next_ramp_second_active ? ramp_second : ramp_first;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ramp_second_active <= 1'b0;
      ramp_active        <= mpss_pkg::RAMP_RESET;
    end else begin
      ramp_second_active <= next_ramp_second_active;
      ramp_active        <= next_ramp_active;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  set_hold_run_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst) && !$past(motor_stopped) |-> motor_set == $past(motor_set))
    else $error("motor set changed while running");

  set_third_wins_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    (|hit_third) && motor_stopped |=> motor_set == mpss_pkg::MPSS_SET_THIRD)
    else $error("third set not taken");

  set_second_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    (|hit_second) && !(|hit_third) && motor_stopped
      |=> motor_set == mpss_pkg::MPSS_SET_SECOND)
    else $error("second set not taken");

  set_first_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    !(|hit_second) && !(|hit_third) && motor_stopped
      |=> motor_set == mpss_pkg::MPSS_SET_FIRST)
    else $error("first set not restored");

  set_third_pin_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    term_pin[0] && input_terminal_func[0] == mpss_pkg::OPT_THIRD_MOTOR
      ##2 motor_stopped && input_terminal_func[0] == mpss_pkg::OPT_THIRD_MOTOR
      |=> motor_set == mpss_pkg::MPSS_SET_THIRD)
    else $error("third set pin path broken");

  ramp_second_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    (|hit_ramp) && ramp_switch_method == mpss_pkg::RAMP_METHOD_TERM
      |=> ramp_second_active && ramp_active == $past(ramp_second))
    else $error("second ramp pair not used");

  ramp_first_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    !(|hit_ramp) |=> !ramp_second_active && ramp_active == $past(ramp_first))
    else $error("first ramp pair not used");

  ramp_switch_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(|hit_ramp) && ramp_switch_method == mpss_pkg::RAMP_METHOD_TERM
      |=> $rose(ramp_second_active))
    else $error("ramp switch delayed");

  ramp_run_free_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    !motor_stopped && $rose(|hit_ramp) && ramp_switch_method == mpss_pkg::RAMP_METHOD_TERM
      |=> ramp_active == $past(ramp_second))
    else $error("running ramp kept its old pair");

  ramp_method_off_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    ramp_switch_method != mpss_pkg::RAMP_METHOD_TERM
      |=> !ramp_second_active && ramp_active == $past(ramp_first))
    else $error("ramp terminal not ignored under another method");

  ramp_pair_match_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst) |-> ramp_active
      == (ramp_second_active ? $past(ramp_second) : $past(ramp_first)))
    else $error("ramp pair and its flag disagree");

  set_pend_apply_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(motor_stopped) && motor_stopped && (|hit_third)
      |=> motor_set == mpss_pkg::MPSS_SET_THIRD)
    else $error("pending set not applied at stop");

  set_onehot_a : assert property (@(posedge sys_clk) disable iff (!nrst)
    $onehot(motor_set))
    else $error("motor set not one-hot");

  // no disable here: this one watches the reset itself
  reset_values_a : assert property (@(posedge sys_clk)
    !nrst |=> motor_set == mpss_pkg::MPSS_SET_FIRST && !ramp_second_active
      && ramp_active == mpss_pkg::RAMP_RESET)
    else $error("outputs not cleared by reset");

endmodule // mpss_select

`default_nettype wire

/* verification/mpss_term_model.sv */
// far-side model: switches or a controller wired to the input terminals.
// assumes the bench calls its tasks just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module mpss_term_model (
  output var logic [7:0] term_pin,
  output var logic [1:0] ramp_switch_method
);
  // contacts held clean between calls; bounce is not modelled
  initial begin
    term_pin           = 8'h00;
    ramp_switch_method = mpss_pkg::RAMP_METHOD_TERM;
  end
  task automatic press(input int slot, input logic lvl);
    term_pin[slot] = lvl;
  endtask
  task automatic method(input logic [1:0] m);
    ramp_switch_method = m;
  endtask
endmodule // mpss_term_model
`default_nettype wire

/* verification/mpss_select_tb.sv */
// self-checking bench for the motor set and ramp pair selector.
// assumes the terminal model drives pins; 3-edge pin latency: two sync flops and the output register.
`timescale 1ns/1ps
`default_nettype none
module mpss_select_tb;
  logic                 sys_clk;
  logic                 nrst;
  logic [7:0][7:0]      input_terminal_func;
  logic                 motor_stopped;
  mpss_pkg::mpss_ramp_t ramp_first;
  mpss_pkg::mpss_ramp_t ramp_second;
  logic [7:0]           term_pin;
  logic [1:0]           ramp_switch_method;
  mpss_pkg::mpss_set_t  motor_set;
  mpss_pkg::mpss_ramp_t ramp_active;
  logic                 ramp_second_active;
  int                   fail_count = 0;
  int                   n_tests = 0;

  mpss_term_model term_inst (
    .term_pin           (term_pin),
    .ramp_switch_method (ramp_switch_method)
  );
  mpss_select mpss_select_inst (
    .sys_clk             (sys_clk),
    .nrst                (nrst),
    .term_pin            (term_pin),
    .input_terminal_func (input_terminal_func),
    .motor_stopped       (motor_stopped),
    .ramp_switch_method  (ramp_switch_method),
    .ramp_first          (ramp_first),
    .ramp_second         (ramp_second),
    .motor_set           (motor_set),
    .ramp_active         (ramp_active),
    .ramp_second_active  (ramp_second_active)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic want_set(input mpss_pkg::mpss_set_t exp);
    check("motor_set", 32'(motor_set), 32'(exp));
  endtask
  task automatic want_ramp(input logic sec);
    check("ramp_active", ramp_active, sec ? ramp_second : ramp_first);
    check("ramp_second_active", 32'(ramp_second_active), 32'(sec));
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    motor_stopped = 1'b1;
    input_terminal_func = '0;
    input_terminal_func[2] = mpss_pkg::OPT_SECOND_MOTOR;
    input_terminal_func[5] = mpss_pkg::OPT_THIRD_MOTOR;
    input_terminal_func[7] = mpss_pkg::OPT_ALT_RAMP;
    ramp_first = '{accel_time: 16'h1111, decel_time: 16'h2222};
    ramp_second = '{accel_time: 16'h3333, decel_time: 16'h4444};
    step(20);
    nrst = 1'b1;
    step(3);
    want_set(mpss_pkg::MPSS_SET_FIRST);
    want_ramp(1'b0);
    term_inst.press(2, 1'b1);
    step(3);
    want_set(mpss_pkg::MPSS_SET_SECOND);
    term_inst.press(5, 1'b1);
    step(3);
    want_set(mpss_pkg::MPSS_SET_THIRD);
    term_inst.press(5, 1'b0);
    step(3);
    want_set(mpss_pkg::MPSS_SET_SECOND);
    term_inst.press(2, 1'b0);
    motor_stopped = 1'b0;
    term_inst.press(5, 1'b1);
    step(6);
    want_set(mpss_pkg::MPSS_SET_SECOND);
    motor_stopped = 1'b1;
    step(1);
    want_set(mpss_pkg::MPSS_SET_THIRD);
    term_inst.press(5, 1'b0);
    step(3);
    want_set(mpss_pkg::MPSS_SET_FIRST);
    // ramp pair swapped while running, as during an acceleration
    motor_stopped = 1'b0;
    term_inst.press(7, 1'b1);
    step(3);
    want_ramp(1'b1);
    ramp_second.accel_time = 16'h5555;
    step(1);
    want_ramp(1'b1);
    term_inst.method(2'h1);
    step(3);
    want_ramp(1'b0);
    term_inst.method(mpss_pkg::RAMP_METHOD_TERM);
    term_inst.press(7, 1'b0);
    step(3);
    want_ramp(1'b0);
    motor_stopped = 1'b1;
    for (int s = 0; s < 8; s++) begin
      input_terminal_func = '0;
      input_terminal_func[s] = mpss_pkg::OPT_SECOND_MOTOR;
      term_inst.press(s, 1'b1);
      step(3);
      want_set(mpss_pkg::MPSS_SET_SECOND);
      term_inst.press(s, 1'b0);
      step(3);
      want_set(mpss_pkg::MPSS_SET_FIRST);
    end
    input_terminal_func = '0;
    input_terminal_func[0] = mpss_pkg::OPT_THIRD_MOTOR;
    term_inst.press(0, 1'b1);
    step(3);
    want_set(mpss_pkg::MPSS_SET_THIRD);
    // reset while running: the held pin must wait for the next stop
    motor_stopped = 1'b0;
    nrst = 1'b0;
    step(2);
    want_set(mpss_pkg::MPSS_SET_FIRST);
    nrst = 1'b1;
    step(3);
    want_set(mpss_pkg::MPSS_SET_FIRST);
    motor_stopped = 1'b1;
    step(1);
    want_set(mpss_pkg::MPSS_SET_THIRD);
    term_inst.press(0, 1'b0);
    step(3);
    want_set(mpss_pkg::MPSS_SET_FIRST);
    conclude();
  end
endmodule // mpss_select_tb
`default_nettype wire
